/* File: verilog/scm_top.v */
// Operation
// - 100 kHz tick output; control logic timed in core cycles
// - tunable 20 MHz clock, four-bit select
// - codes 0-4 map 20-24, 9-C 16-19
// - step through intermediates, 5.2 us dwell
// - set ready flag on reaching target
// - switching rate is hf clock over 8
// - select loads from default at power up
// - no manual tuning during spread or while the external source is active
// - spread enable bit, default from otp
// - spread range 5 or 10 percent
// - 24 kHz modulation on internal source
// - spread forced off while sync enabled
// - sync disabled: pll off, internal only
// - sync enabled: pll on, either source
// - valid sync band per band select
// - fallback to internal, set fault flag
// - fault status follows validity
// - return only after flag clear, valid
// - sync output toggles or held low
`timescale 1ns/100ps
`include "scm_map.vh"
module scm_top (
  input  wire       core_clk,
  input  wire       reset,
  input  wire [3:0] hf_clock_freq_default,
  input  wire       spread_enable_default,
  input  wire       spread_range_default,
  input  wire       ext_sync_enable_default,
  input  wire       ext_sync_band_default,
  input  wire       sync_output_default,
  input  wire       cfg_write,
  input  wire [3:0] hf_clock_freq_select,
  input  wire       spread_enable,
  input  wire       spread_range_select,
  input  wire       ext_sync_band_select,
  input  wire       sync_output_enable,
  input  wire       freq_reached_mask,
  input  wire       ext_sync_fault_mask,
  input  wire       freq_reached_clear,
  input  wire       ext_sync_fault_clear,
  input  wire       ext_sync_input,
  output reg  [3:0] hf_clock_freq_now,
  output reg        switching_tick,
  output reg        pll_enable,
  output reg        ext_source_active,
  output reg        spread_active,
  output reg  [3:0] spread_offset,
  output reg        lf_tick,
  output reg        freq_reached_irq_flag,
  output reg        ext_sync_fault_irq_flag,
  output reg        ext_sync_fault_status,
  output reg        irq_out_n,
  output reg        sync_output_pin
);

  // ----------------------------------------------------------------
  // code to linear index: 16 MHz is 0, 24 MHz is 8
  // ----------------------------------------------------------------
  function [3:0] code_to_idx;
    input [3:0] c;
    begin
      if (c <= `SCM_CODE_24M)
        code_to_idx = c + 4'h4;
      else if (c >= `SCM_CODE_16M && c <= `SCM_CODE_19M)
        code_to_idx = c - 4'h9;
      else
        code_to_idx = 4'h4;
    end
  endfunction

  function [3:0] idx_to_code;
    input [3:0] i;
    begin
      if (i >= 4'h4)
        idx_to_code = i - 4'h4;
      else
        idx_to_code = i + 4'h9;
    end
  endfunction

  function code_used;
    input [3:0] c;
    begin
      code_used = (c <= `SCM_CODE_24M) ||
                  (c >= `SCM_CODE_16M && c <= `SCM_CODE_19M);
    end
  endfunction

  // ----------------------------------------------------------------
  // settings, loaded from defaults in the cycle after reset release
  // ----------------------------------------------------------------
  reg       init_q;
  reg [3:0] target_q;
  reg [3:0] cur_idx_q;
  reg       spr_en_q;
  reg       spr_rng_q;
  reg       sync_en_q;
  reg       band_q;
  reg       sout_en_q;
  reg       stepping_q;

  always @(posedge core_clk) begin
    if (reset) begin
      init_q     <= 1'b1;
      target_q   <= 4'h4;
      spr_en_q   <= 1'b0;
      spr_rng_q  <= 1'b0;
      sync_en_q  <= 1'b0;
      band_q     <= 1'b0;
      sout_en_q  <= 1'b0;
    end else if (init_q) begin
      // straps caught after reset release, not under it
      init_q     <= 1'b0;
      target_q   <= code_to_idx(hf_clock_freq_default);
      spr_en_q   <= spread_enable_default;
      spr_rng_q  <= spread_range_default;
      sync_en_q  <= ext_sync_enable_default;
      band_q     <= ext_sync_band_default;
      sout_en_q  <= sync_output_default;
    end else if (cfg_write) begin
      // unused codes are ignored; target keeps its last value
      if (code_used(hf_clock_freq_select))
        target_q <= code_to_idx(hf_clock_freq_select);
      spr_en_q   <= spread_enable;
      spr_rng_q  <= spread_range_select;
      band_q     <= ext_sync_band_select;
      sout_en_q  <= sync_output_enable;
    end
  end

  // ----------------------------------------------------------------
  // 100 kHz tick output, not used by the logic timers
  // ----------------------------------------------------------------
  reg [7:0] lf_cnt_q;
  always @(posedge core_clk) begin
    if (reset) begin
      lf_cnt_q <= 8'h00;
      lf_tick  <= 1'b0;
    end else if (lf_cnt_q == `SCM_LF_DIV - 1) begin
      lf_cnt_q <= 8'h00;
      lf_tick  <= 1'b1;
    end else begin
      lf_cnt_q <= lf_cnt_q + 8'h01;
      lf_tick  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // gradual stepping toward target
  // ----------------------------------------------------------------
  wire      tuning_ok = !spread_active && !ext_source_active;
  reg [7:0] dwell_q;
  reg       reach_ev;

  always @(posedge core_clk) begin
    if (reset || init_q) begin
      cur_idx_q  <= init_q ? code_to_idx(hf_clock_freq_default) : 4'h4;
      dwell_q    <= 8'h00;
      stepping_q <= 1'b0;
      reach_ev   <= 1'b0;
    end else begin
      reach_ev <= 1'b0;
      if (!tuning_ok || cur_idx_q == target_q) begin
        dwell_q <= 8'h00;
        if (stepping_q && cur_idx_q == target_q)
          reach_ev <= 1'b1;
        stepping_q <= 1'b0;
      end else if (dwell_q == `SCM_STEP_CYC - 1) begin
        dwell_q    <= 8'h00;
        stepping_q <= 1'b1;
        // one step per dwell, every intermediate visited
        cur_idx_q  <= (target_q > cur_idx_q) ? cur_idx_q + 4'h1
                                             : cur_idx_q - 4'h1;
      end else begin
        dwell_q    <= dwell_q + 8'h01;
        stepping_q <= 1'b1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (reset)
      hf_clock_freq_now <= `SCM_CODE_20M;
    else
      hf_clock_freq_now <= idx_to_code(cur_idx_q);
  end

  // ----------------------------------------------------------------
  // external sync period check
  // ----------------------------------------------------------------
  reg        sin_q;
  reg [15:0] per_q;
  reg        valid_q;

  wire [15:0] lo_lim = band_q ? `SCM_LO_BAND_MIN_CYC : `SCM_HI_BAND_MIN_CYC;
  wire [15:0] hi_lim = band_q ? `SCM_LO_BAND_MAX_CYC : `SCM_HI_BAND_MAX_CYC;

  always @(posedge core_clk) begin
    if (reset) begin
      sin_q   <= 1'b0;
      per_q   <= 16'h0000;
      valid_q <= 1'b0;
    end else begin
      sin_q <= ext_sync_input;
      if (ext_sync_input && !sin_q) begin
        per_q   <= 16'h0001;
        valid_q <= (per_q >= lo_lim) && (per_q <= hi_lim);
      end else if (per_q > hi_lim || per_q == `SCM_SYNC_TMO_CYC) begin
        // stopped clock or too slow: invalid at once
        valid_q <= 1'b0;
        per_q   <= per_q;
      end else begin
        per_q <= per_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // source select, flags, interrupt
  // ----------------------------------------------------------------
  wire fault_now = sync_en_q && !valid_q;

  always @(posedge core_clk) begin
    if (reset) begin
      pll_enable              <= 1'b0;
      ext_source_active       <= 1'b0;
      ext_sync_fault_status   <= 1'b0;
      ext_sync_fault_irq_flag <= 1'b0;
      freq_reached_irq_flag   <= 1'b0;
      irq_out_n               <= 1'b1;
    end else begin
      pll_enable            <= sync_en_q;
      ext_sync_fault_status <= fault_now;
      if (!sync_en_q || fault_now)
        ext_source_active <= 1'b0;
      else if (!ext_sync_fault_irq_flag && valid_q)
        ext_source_active <= 1'b1;
      // set wins over clear
      if (fault_now && ext_source_active)
        ext_sync_fault_irq_flag <= 1'b1;
      else if (fault_now && !ext_sync_fault_status)
        ext_sync_fault_irq_flag <= 1'b1;
      else if (ext_sync_fault_clear)
        ext_sync_fault_irq_flag <= 1'b0;
      if (reach_ev)
        freq_reached_irq_flag <= 1'b1;
      else if (freq_reached_clear)
        freq_reached_irq_flag <= 1'b0;
      irq_out_n <= !((freq_reached_irq_flag && !freq_reached_mask) ||
                     (ext_sync_fault_irq_flag && !ext_sync_fault_mask));
    end
  end

  // ----------------------------------------------------------------
  // spread spectrum square wave at 24 kHz
  // ----------------------------------------------------------------
  reg [9:0] ssm_cnt_q;
  reg       ssm_up_q;
  wire [3:0] spr_lim = spr_rng_q ? `SCM_SPREAD_WIDE : `SCM_SPREAD_NARROW;

  always @(posedge core_clk) begin
    if (reset) begin
      spread_active <= 1'b0;
      spread_offset <= 4'h0;
      ssm_cnt_q     <= 10'h000;
      ssm_up_q      <= 1'b1;
    end else begin
      spread_active <= spr_en_q && !sync_en_q && !init_q;
      if (!spread_active) begin
        spread_offset <= 4'h0;
        ssm_cnt_q     <= 10'h000;
      end else if (ssm_cnt_q == `SCM_SSM_HALF - 1) begin
        ssm_cnt_q <= 10'h000;
        ssm_up_q  <= !ssm_up_q;
        spread_offset <= ssm_up_q ? spr_lim : 4'h0;
      end else begin
        ssm_cnt_q <= ssm_cnt_q + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // divide by 8 and sync output
  // ----------------------------------------------------------------
  reg [2:0] sw_cnt_q;
  wire      base_src = ext_source_active ? sin_q : sw_cnt_q[2];

  always @(posedge core_clk) begin
    if (reset) begin
      sw_cnt_q        <= 3'h0;
      switching_tick  <= 1'b0;
      sync_output_pin <= 1'b0;
    end else begin
      sw_cnt_q       <= sw_cnt_q + 3'h1;
      switching_tick <= (sw_cnt_q == `SCM_SW_DIV - 1);
      sync_output_pin <= sout_en_q ? base_src : 1'b0;
    end
  end

endmodule

/* File: shared/scm_map.vh */
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
// ----------------------------------------------------------------
// clock rates and timing
// ----------------------------------------------------------------
`define SCM_CORE_HZ          20000000
`define SCM_LF_HZ            100000
`define SCM_LF_DIV           (`SCM_CORE_HZ / `SCM_LF_HZ)
`define SCM_STEP_NS          5200
`define SCM_CORE_NS          50
`define SCM_STEP_CYC         ((`SCM_STEP_NS + `SCM_CORE_NS - 1) / `SCM_CORE_NS)
`define SCM_SSM_HZ           24000
`define SCM_SSM_HALF         (`SCM_CORE_HZ / (2 * `SCM_SSM_HZ))
`define SCM_SW_DIV           8
// ----------------------------------------------------------------
// frequency select codes
// ----------------------------------------------------------------
`define SCM_CODE_20M         4'h0
`define SCM_CODE_24M         4'h4
`define SCM_CODE_16M         4'h9
`define SCM_CODE_19M         4'hc
// ----------------------------------------------------------------
// external sync band limits, counted in core cycles per period
// ----------------------------------------------------------------
`define SCM_HI_BAND_MIN_CYC  16'h0006
`define SCM_HI_BAND_MAX_CYC  16'h000a
`define SCM_LO_BAND_MIN_CYC  16'h0028
`define SCM_LO_BAND_MAX_CYC  16'h003c
`define SCM_SYNC_TMO_CYC     16'h0050
// ----------------------------------------------------------------
// spread ranges in steps of 1 MHz offset units (index scale)
// ----------------------------------------------------------------
`define SCM_SPREAD_NARROW    4'h1
`define SCM_SPREAD_WIDE      4'h2
`endif

/* File: test/scm_top_asserts.sv */
`timescale 1ns/100ps
module scm_top_chk (
  input wire       core_clk,
  input wire       reset,
  input wire       freq_reached_mask,
  input wire       freq_reached_clear,
  input wire [3:0] hf_clock_freq_now,
  input wire       switching_tick,
  input wire       pll_enable,
  input wire       ext_source_active,
  input wire       spread_active,
  input wire       lf_tick,
  input wire       freq_reached_irq_flag,
  input wire       ext_sync_fault_irq_flag,
  input wire       ext_sync_fault_status,
  input wire       irq_out_n
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_lf; lf_tick |=> !lf_tick [*8] ##192 lf_tick; endproperty
  a_lf: assert property (p_lf) else $error("lf tick spacing");
  property p_sw;
    switching_tick && !pll_enable |=> !switching_tick [*7] ##1 switching_tick;
  endproperty
  a_sw: assert property (p_sw) else $error("switching divide");
  property p_frz; spread_active |=> $stable(hf_clock_freq_now); endproperty
  a_frz: assert property (p_frz) else $error("tuning in spread");
  property p_nospr; pll_enable |-> !spread_active; endproperty
  a_nospr: assert property (p_nospr) else $error("spread with sync");
  property p_nopll; !pll_enable |-> !ext_source_active; endproperty
  a_nopll: assert property (p_nopll) else $error("ext without pll");
  property p_irq; freq_reached_irq_flag && !freq_reached_mask |=> !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not driven");
  property p_idle;
    !freq_reached_irq_flag && !ext_sync_fault_irq_flag |=> irq_out_n;
  endproperty
  a_idle: assert property (p_idle) else $error("irq without flag");
  property p_hold;
    freq_reached_irq_flag && !freq_reached_clear |=> freq_reached_irq_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_fb; $rose(ext_sync_fault_status) |->
    ##[0:2] (!ext_source_active && ext_sync_fault_irq_flag); endproperty
  a_fb: assert property (p_fb) else $error("no fallback");
  property p_back;
    $rose(ext_source_active) |-> !$past(ext_sync_fault_irq_flag);
  endproperty
  a_back: assert property (p_back) else $error("early return");
  c_rdy: cover property ($rose(freq_reached_irq_flag));
  c_ext: cover property ($rose(ext_source_active));
  c_fb: cover property ($fell(ext_source_active));
endmodule
bind scm_top scm_top_chk scm_top_chk_inst (.*);

/* File: test/scm_sync_src.sv */
`timescale 1ns/100ps
module scm_sync_src (
  input  wire       core_clk,
  input  wire       run,
  input  wire [7:0] half_cyc,
  output reg        ext_sync_input
);
  reg [7:0] cnt_q;
  initial begin
    ext_sync_input = 1'b0;
    cnt_q = 8'h00;
  end
  // square wave, even duty, period twice half_cyc core cycles
  always @(posedge core_clk) begin
    if (!run) begin
      ext_sync_input <= 1'b0;
      cnt_q <= 8'h00;
    end else if (cnt_q + 8'h01 >= half_cyc) begin
      ext_sync_input <= ~ext_sync_input;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: test/test_scm_top.sv */
`timescale 1ns/100ps
module test_scm_top;
  reg        core_clk, reset, cfg_write, src_run;
  reg        spread_enable_default, spread_range_default;
  reg        ext_sync_enable_default, ext_sync_band_default;
  reg        sync_output_default, spread_enable, spread_range_select;
  reg        ext_sync_band_select, sync_output_enable;
  reg        freq_reached_mask, ext_sync_fault_mask;
  reg        freq_reached_clear, ext_sync_fault_clear;
  reg  [3:0] hf_clock_freq_default, hf_clock_freq_select, hi;
  reg  [7:0] src_half;
  wire [3:0] hf_clock_freq_now, spread_offset;
  wire       switching_tick, pll_enable, ext_source_active, spread_active;
  wire       lf_tick, freq_reached_irq_flag, ext_sync_fault_irq_flag;
  wire       ext_sync_fault_status, irq_out_n, sync_output_pin;
  wire       ext_sync_input;
  integer    err_total, checked, cycles, k;
  scm_top scm_top_inst (.*);
  scm_sync_src scm_sync_src_inst (.core_clk(core_clk), .run(src_run),
    .half_cyc(src_half), .ext_sync_input(ext_sync_input));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task chk(input [3:0] got, input [3:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task boot(input sync_en);
    begin
      @(posedge core_clk) ext_sync_enable_default <= sync_en;
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask
  // bits: spread, range, band, sync out
  task wr(input [3:0] code, input [3:0] bits);
    begin
      @(posedge core_clk) hf_clock_freq_select <= code;
      {spread_enable, spread_range_select, ext_sync_band_select,
       sync_output_enable} <= bits;
      cfg_write <= 1'b1;
      @(posedge core_clk) cfg_write <= 1'b0;
    end
  endtask
  task clr(input [1:0] which);
    begin
      @(posedge core_clk) {freq_reached_clear, ext_sync_fault_clear} <= which;
      @(posedge core_clk) {freq_reached_clear, ext_sync_fault_clear} <= 2'b00;
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask
  task highs;
    begin
      hi = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        wt(1);
        hi = hi + {3'b000, sync_output_pin};
      end
    end
  endtask
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {reset, cfg_write, src_run, spread_enable, spread_range_select} = 5'h10;
    {ext_sync_band_select, sync_output_enable, ext_sync_fault_mask} = 3'h0;
    {freq_reached_clear, ext_sync_fault_clear, freq_reached_mask} = 3'h0;
    {spread_enable_default, spread_range_default} = 2'b00;
    {ext_sync_enable_default, ext_sync_band_default} = 2'b00;
    sync_output_default = 1'b1;
    hf_clock_freq_default = 4'h0;
    hf_clock_freq_select = 4'h0;
    src_half = 8'h04;
    {err_total, checked, cycles} = 0;
    boot(1'b0);
    chk(hf_clock_freq_now, 4'h0);
    chk({3'b000, pll_enable}, 4'h0);
    wr(4'h2, 4'h1);
    wt(110);
    chk(hf_clock_freq_now, 4'h1);
    wt(120);
    chk(hf_clock_freq_now, 4'h2);
    chk({3'b000, freq_reached_irq_flag}, 4'h1);
    chk({3'b000, irq_out_n}, 4'h0);
    clr(2'b10);
    @(posedge core_clk) freq_reached_mask <= 1'b1;
    wr(4'hc, 4'h1);
    wt(110);
    chk(hf_clock_freq_now, 4'h1);
    wt(250);
    chk(hf_clock_freq_now, 4'hc);
    chk({freq_reached_irq_flag, 2'b00, irq_out_n}, 4'h9);
    highs;
    chk(hi, 4'h8);
    wr(4'h5, 4'h0);
    highs;
    chk(hi, 4'h0);
    wt(250);
    chk(hf_clock_freq_now, 4'hc);
    wr(4'h0, 4'h8);
    wt(250);
    chk({3'b000, spread_active}, 4'h1);
    chk(hf_clock_freq_now, 4'hc);
    wt(200);
    chk(spread_offset, 4'h1);
    @(posedge core_clk) spread_enable_default <= 1'b1;
    boot(1'b1);
    chk({pll_enable, 2'b00, spread_active}, 4'h8);
    wt(100);
    chk({ext_sync_fault_status, ext_source_active, 1'b0, irq_out_n}, 4'h8);
    @(posedge core_clk) src_run <= 1'b1;
    wt(60);
    chk({ext_sync_fault_status, ext_source_active, 2'b00}, 4'h0);
    clr(2'b01);
    wt(20);
    chk({3'b000, ext_source_active}, 4'h1);
    @(posedge core_clk) src_half <= 8'h0a;
    wt(100);
    chk({ext_sync_fault_status, ext_sync_fault_irq_flag, 1'b0,
         ext_source_active}, 4'hc);
    wr(4'h0, 4'h2);
    @(posedge core_clk) src_half <= 8'h19;
    wt(150);
    clr(2'b01);
    wt(20);
    chk({ext_sync_fault_status, 2'b00, ext_source_active}, 4'h1);
    print_verdict;
  end
endmodule
